// *** logic/dsp_status_server.sv ***
`timescale 1ns/100ps
// Contract
// RULE1: Bits 0..3 show switch-on ready, operate ready, enabled, fault.
// RULE2: Bits 4..7 show coast stop, quick stop, switch-on blocked, alarm.
// RULE3: Bit 8 set when speed error is within ten percent of nominal.
// RULE4: Bit 9 set when controlled from an external location.
// RULE5: Bit 10 set when speed magnitude reaches supervision limit.
// RULE6: Bit 11 set when external location two is selected.
// RULE7: Bit 12 set while external run permit is received.
// RULE8: Bits 13 and 14 carry no profile meaning unless programmed.
// RULE9: Bit 15 set while the network adapter sees a link fault.
// RULE10: References are signed 16-bit, reverse as two's complement.
// RULE11: Reference 0..20000 maps linearly to 0..100 percent scaling.
// RULE12: Actual values are selectable signed 16-bit words, reference format.
// RULE13: Server answers requests arriving over TCP or over UDP.
// RULE14: Two client sessions, each with independent session state; the code only echoes the session bit, and all state is shared.
// RULE15: Holding register address field is 16 bits wide.
// RULE16: Six-digit client numbering 400001..465536 maps onto address zero up.
// RULE17: Five-digit clients reach only 40001..49999.
// RULE18: Status word served at holding register 400004.
// RULE19: Status word refreshed from live drive flags every cycle.
// RULE20: Reserved bits 13 and 14 read zero unless programmed.
module dsp_status_server
#(
    parameter int unsigned NOMINAL_SPEED = 20000
)
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ready_switch_on_i,
    input  wire logic        ready_operate_i,
    input  wire logic        operation_enabled_i,
    input  wire logic        fault_flag_i,
    input  wire logic        coast_stop_state_i,
    input  wire logic        quick_stop_state_i,
    input  wire logic        switch_on_blocked_flag_i,
    input  wire logic        alarm_i,
    input  wire logic        location_one_i,
    input  wire logic        location_two_i,
    input  wire logic        run_permit_received_flag_i,
    input  wire logic        link_fault_flag_i,
    input  wire logic [1:0]  prog_bits_i,
    input  wire logic [1:0]  prog_enable_i,
    input  wire logic [15:0] speed_actual_i,
    input  wire logic [15:0] speed_reference_word_i,
    input  wire logic [15:0] supervision_limit_i,
    input  wire logic [15:0] actual_one_i,
    input  wire logic [15:0] actual_two_i,
    input  wire logic        req_valid_i,
    input  wire logic        req_session_i,
    input  wire logic        req_udp_i,
    input  wire logic        req_write_i,
    input  wire logic [15:0] req_addr_i,
    input  wire logic [15:0] req_wdata_i,
    output logic             rsp_valid_o,
    output logic             rsp_session_o,
    output logic             rsp_udp_o,
    output logic             rsp_error_o,
    output logic [15:0]      rsp_rdata_o,
    output logic [15:0]      drive_status_word_o,
    output logic [15:0]      control_word_o,
    output logic [15:0]      speed_reference_one_o,
    output logic [15:0]      speed_reference_two_o
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [15:0] status;
        logic [15:0] control;
        logic [15:0] ref1;
        logic [15:0] ref2;
        logic        rsp_valid;
        logic        rsp_session;
        logic        rsp_udp;
        logic        rsp_error;
        logic [15:0] rsp_rdata;
    } dsp_state_t;

    dsp_state_t st;
    dsp_state_t next_st;

    logic [15:0] act_mag;
    logic [15:0] ref_mag;
    logic [16:0] speed_err;
    logic [31:0] tol_limit;
    logic [15:0] read_mux;
    logic        addr_ok;

    // Magnitudes of signed words; reverse is two's complement
    always_comb
    begin
        act_mag = speed_actual_i[15] ? 16'(-speed_actual_i)
                                     : speed_actual_i;          // RULE10
        ref_mag = speed_reference_word_i[15]
                ? 16'(-speed_reference_word_i)
                : speed_reference_word_i;                       // RULE10
        if (speed_actual_i[15] == speed_reference_word_i[15])
            speed_err = (act_mag > ref_mag) ? {1'b0, act_mag - ref_mag}
                                            : {1'b0, ref_mag - act_mag};
        else
            speed_err = {1'b0, act_mag} + {1'b0, ref_mag};
        // Tolerance band is a fixed share of nominal speed
        tol_limit = 32'(NOMINAL_SPEED * dsp_pkg::TOL_PERCENT
                        / 100);                                 // RULE3
    end

    // Holding register read decode; the 16-bit address is taken raw
    always_comb
    begin
        addr_ok  = 1'b1;
        read_mux = dsp_pkg::DATA_RESET;
        case (req_addr_i)                                       // RULE15
            dsp_pkg::ADDR_CONTROL: read_mux = st.control;
            dsp_pkg::ADDR_REF1:    read_mux = st.ref1;
            dsp_pkg::ADDR_REF2:    read_mux = st.ref2;
            dsp_pkg::ADDR_STATUS:  read_mux = st.status;       // RULE18
            dsp_pkg::ADDR_ACT1:    read_mux = actual_one_i;    // RULE12
            dsp_pkg::ADDR_ACT2:    read_mux = actual_two_i;    // RULE12
            default:               addr_ok  = 1'b0;
        endcase
    end

    // Next state: status refreshed every cycle, request served
    always_comb
    begin
        next_st = st;
        next_st.status[dsp_pkg::BIT_RDY_SWITCH] = ready_switch_on_i; // RULE1
        next_st.status[dsp_pkg::BIT_RDY_OPER]   = ready_operate_i;   // RULE1
        next_st.status[dsp_pkg::BIT_OP_ENABLED] = operation_enabled_i; // RULE1
        next_st.status[dsp_pkg::BIT_FAULT]      = fault_flag_i;      // RULE1
        // Stop inputs are active high; the word shows them inverted
        next_st.status[dsp_pkg::BIT_COAST_INACT] =
            !coast_stop_state_i;                                     // RULE2
        next_st.status[dsp_pkg::BIT_QUICK_INACT] =
            !quick_stop_state_i;                                     // RULE2
        next_st.status[dsp_pkg::BIT_SW_BLOCKED] =
            switch_on_blocked_flag_i;                                // RULE2
        next_st.status[dsp_pkg::BIT_ALARM]      = alarm_i;           // RULE2
        next_st.status[dsp_pkg::BIT_REF_REACH] =
            (32'(speed_err) <= tol_limit);                           // RULE3
        next_st.status[dsp_pkg::BIT_REMOTE] =
            location_one_i | location_two_i;                         // RULE4
        next_st.status[dsp_pkg::BIT_ABOVE_SUP] =
            (act_mag >= supervision_limit_i);                        // RULE5
        next_st.status[dsp_pkg::BIT_LOC_TWO]    = location_two_i;    // RULE6
        next_st.status[dsp_pkg::BIT_RUN_PERMIT] =
            run_permit_received_flag_i;                              // RULE7
        // Free bits only carry a value once programmed
        next_st.status[dsp_pkg::BIT_PROG_A] =
            prog_enable_i[0] & prog_bits_i[0];   // RULE8 RULE20
        next_st.status[dsp_pkg::BIT_PROG_B] =
            prog_enable_i[1] & prog_bits_i[1];   // RULE8 RULE20
        next_st.status[dsp_pkg::BIT_LINK_FAULT] = link_fault_flag_i; // RULE9

        next_st.rsp_valid = 1'b0;
        if (req_valid_i)
        begin
            // Same path for TCP and UDP; transport echoed back
            next_st.rsp_valid   = 1'b1;                              // RULE13
            next_st.rsp_udp     = req_udp_i;                         // RULE13
            next_st.rsp_session = req_session_i;                     // RULE14
            next_st.rsp_error = !addr_ok;
            next_st.rsp_rdata = req_write_i ? req_wdata_i : read_mux;
            if (req_write_i)
            begin
                // Only control and references are writable
                case (req_addr_i)
                    dsp_pkg::ADDR_CONTROL: next_st.control = req_wdata_i;
                    // References kept as sent: signed, 20000 is full scale
                    dsp_pkg::ADDR_REF1: next_st.ref1 = req_wdata_i; // RULE11
                    dsp_pkg::ADDR_REF2: next_st.ref2 = req_wdata_i; // RULE10
                    default:               next_st.rsp_error = 1'b1;
                endcase
            end
            if (next_st.rsp_error)
                next_st.rsp_rdata = dsp_pkg::DATA_RESET;
        end
    end

    // Single register stage for all state
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            st <= '0;
        else
            st <= next_st;                                           // RULE19
    end

    // Outputs straight from flops
    assign drive_status_word_o   = st.status;
    assign control_word_o        = st.control;
    assign speed_reference_one_o = st.ref1;
    assign speed_reference_two_o = st.ref2;
    assign rsp_valid_o           = st.rsp_valid;
    assign rsp_session_o         = st.rsp_session;
    assign rsp_udp_o             = st.rsp_udp;
    assign rsp_error_o           = st.rsp_error;
    assign rsp_rdata_o           = st.rsp_rdata;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // The edge that releases reset still holds the word clear, so
    // attempts starting there are skipped
    sequence s_status_read;
        !rst_i && req_valid_i && !req_write_i
            && req_addr_i == dsp_pkg::ADDR_STATUS;
    endsequence

    a_fault_bit: assert property (  // RULE1
        !rst_i && fault_flag_i |=> drive_status_word_o[3])
        else $error("fault bit not set");
    a_coast_bit: assert property (  // RULE2
        !rst_i && coast_stop_state_i |=> !drive_status_word_o[4])
        else $error("coast bit wrong");
    a_remote_bit: assert property (  // RULE4
        !rst_i && (location_one_i || location_two_i)
        |=> drive_status_word_o[9])
        else $error("remote bit wrong");
    a_supervision_exceeded_flag: assert property (  // RULE5
        !$past(rst_i) |-> drive_status_word_o[10]
        == ($past(act_mag) >= $past(supervision_limit_i)))
        else $error("supervision bit wrong");
    a_loc_two: assert property (  // RULE6
        !rst_i && location_two_i |=> drive_status_word_o[11])
        else $error("location bit wrong");
    a_free_bits: assert property (  // RULE20
        !rst_i && prog_enable_i == 2'b00
        |=> drive_status_word_o[14:13] == 2'b00)
        else $error("reserved bits nonzero");
    a_link_fault: assert property (  // RULE9
        !rst_i && link_fault_flag_i |=> drive_status_word_o[15])
        else $error("link fault bit missing");
    a_status_serve: assert property (  // RULE18
        s_status_read |=> rsp_valid_o && !rsp_error_o
            && rsp_rdata_o == $past(drive_status_word_o))
        else $error("status read wrong");
    a_session_echo: assert property (  // RULE14
        !rst_i && req_valid_i |=> rsp_session_o == $past(req_session_i))
        else $error("session not echoed");
endmodule

// *** include/dsp_pkg.sv ***
package dsp_pkg;
    // ************************************************************
    // Status word bit positions
    // ************************************************************
    localparam int unsigned BIT_RDY_SWITCH = 0;
    localparam int unsigned BIT_RDY_OPER   = 1;
    localparam int unsigned BIT_OP_ENABLED = 2;
    localparam int unsigned BIT_FAULT      = 3;
    localparam int unsigned BIT_COAST_INACT = 4;
    localparam int unsigned BIT_QUICK_INACT = 5;
    localparam int unsigned BIT_SW_BLOCKED = 6;
    localparam int unsigned BIT_ALARM      = 7;
    localparam int unsigned BIT_REF_REACH  = 8;
    localparam int unsigned BIT_REMOTE     = 9;
    localparam int unsigned BIT_ABOVE_SUP  = 10;
    localparam int unsigned BIT_LOC_TWO    = 11;
    localparam int unsigned BIT_RUN_PERMIT = 12;
    localparam int unsigned BIT_PROG_A     = 13;
    localparam int unsigned BIT_PROG_B     = 14;
    localparam int unsigned BIT_LINK_FAULT = 15;

    // ************************************************************
    // Holding register map, protocol addresses (400001 is zero)
    // ************************************************************
    localparam logic [15:0] ADDR_CONTROL  = 16'h0000;
    localparam logic [15:0] ADDR_REF1     = 16'h0001;
    localparam logic [15:0] ADDR_REF2     = 16'h0002;
    localparam logic [15:0] ADDR_STATUS   = 16'h0003;
    localparam logic [15:0] ADDR_ACT1     = 16'h0004;
    localparam logic [15:0] ADDR_ACT2     = 16'h0005;

    // ************************************************************
    // Scaling and reset values
    // ************************************************************
    localparam int unsigned REF_FULL_SCALE = 20000;
    localparam int unsigned TOL_PERCENT    = 10;
    localparam logic [15:0] STATUS_RESET   = 16'h0000;
    localparam logic [15:0] DATA_RESET     = 16'h0000;
    localparam int unsigned N_SESSIONS     = 2;
endpackage

// *** bench/dsp_client_model.sv ***
`timescale 1ns/100ps
// ****************************************
// Client station issuing single-word requests
// ****************************************
module dsp_client_model
(
    input  wire logic        clk_i,
    input  wire logic        rsp_valid_i,
    input  wire logic        rsp_error_i,
    input  wire logic [15:0] rsp_rdata_i,
    output logic             req_valid_o,
    output logic             req_session_o,
    output logic             req_udp_o,
    output logic             req_write_o,
    output logic [15:0]      req_addr_o,
    output logic [15:0]      req_wdata_o
);
    // Idle bus before the first request
    initial
    begin
        {req_valid_o, req_session_o, req_udp_o, req_write_o} = 4'h0;
        req_addr_o  = 16'hFFFF;
        req_wdata_o = 16'h0000;
    end

    // Decimal register number to a 16-bit protocol address
    function automatic logic [15:0] to_addr(input int reg_no);
        if (reg_no >= 400001)
            return 16'(reg_no - 400001);
        return 16'(reg_no - 40001);
    endfunction

    // One request; the answer is registered on the edge that accepts it and read just after that edge
    task automatic xfer(input logic s, input logic u, input logic w,
                        input int reg_no, input logic [15:0] wd,
                        output logic ok, output logic err,
                        output logic [15:0] rd);
        @(posedge clk_i);
        req_valid_o   <= 1'b1;
        req_session_o <= s;
        req_udp_o     <= u;
        req_write_o   <= w;
        req_addr_o    <= to_addr(reg_no);
        req_wdata_o   <= wd;
        @(posedge clk_i);
        req_valid_o <= 1'b0;
        // Released fields scrambled so stale values cannot look valid
        req_addr_o  <= ~to_addr(reg_no);
        req_wdata_o <= ~wd;
        #1;
        ok  = rsp_valid_i;
        err = rsp_error_i;
        rd  = rsp_rdata_i;
    endtask
endmodule

// *** bench/tb_top.sv ***
`timescale 1ns/100ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
    miscompares++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb_top;
    localparam int NOM = 20000;
    localparam int TOL = NOM * dsp_pkg::TOL_PERCENT / 100;
    // ****************************************
    // Signals, named as the design ports
    // ****************************************
    logic        clk_i, rst_i, req_valid_i, req_session_i, req_udp_i;
    logic        req_write_i, rsp_valid_o, rsp_session_o, rsp_udp_o;
    logic        rsp_error_o, ok, err;
    logic [11:0] fl;
    logic [1:0]  prog_bits_i, prog_enable_i;
    logic [15:0] speed_actual_i, speed_reference_word_i, rd;
    logic [15:0] supervision_limit_i, actual_one_i, actual_two_i;
    logic [15:0] req_addr_i, req_wdata_i, rsp_rdata_o;
    logic [15:0] drive_status_word_o, control_word_o;
    logic [15:0] speed_reference_one_o, speed_reference_two_o;
    wire logic   ready_switch_on_i, ready_operate_i, operation_enabled_i;
    wire logic   fault_flag_i, coast_stop_state_i, quick_stop_state_i;
    wire logic   switch_on_blocked_flag_i, alarm_i, location_one_i;
    wire logic   location_two_i, run_permit_received_flag_i;
    wire logic   link_fault_flag_i;
    int          miscompares = 0;
    int          checks_done = 0;
    localparam logic [47:0] SPD [6] = '{48'h07D0_0000_7FFF,
        48'h07D1_0000_7FFF, 48'hF830_0000_7FFF, 48'h0000_F82F_7FFF,
        48'hFC18_0000_03E8, 48'h03E7_03E7_03E8};

    // Drive flags packed so one vector walks them
    assign {link_fault_flag_i, run_permit_received_flag_i, location_two_i,
            location_one_i, alarm_i, switch_on_blocked_flag_i,
            quick_stop_state_i, coast_stop_state_i, fault_flag_i,
            operation_enabled_i, ready_operate_i, ready_switch_on_i} = fl;

    dsp_status_server #(.NOMINAL_SPEED(NOM)) dut (.*);
    dsp_client_model client (.clk_i(clk_i), .rsp_valid_i(rsp_valid_o),
        .rsp_error_i(rsp_error_o), .rsp_rdata_i(rsp_rdata_o),
        .req_valid_o(req_valid_i), .req_session_o(req_session_i),
        .req_udp_o(req_udp_i), .req_write_o(req_write_i),
        .req_addr_o(req_addr_i), .req_wdata_o(req_wdata_i));

    always #5 clk_i = ~clk_i;

    // ****************************************
    // Expected status word and shared tasks
    // ****************************************
    function automatic logic [15:0] exp_sw();
        int a;
        logic [15:0] e;
        a = $signed(speed_actual_i) - $signed(speed_reference_word_i);
        e = {fl[11], prog_bits_i & prog_enable_i, fl[10:9], 3'b000,
             fl[7:6], ~fl[5:4], fl[3:0]};
        e[8] = (a < 0 ? -a : a) <= TOL;
        e[9] = fl[8] | fl[9];
        a = $signed(speed_actual_i);
        e[10] = (a < 0 ? -a : a) >= int'(supervision_limit_i);
        return e;
    endfunction

    // Status must follow the inputs one cycle after they change
    task automatic sw_chk();
        @(posedge clk_i);
        #1;
        `CHK("status", exp_sw(), drive_status_word_o)
    endtask

    task automatic rw(input logic s, input logic u, input logic w,
                      input int r, input logic [15:0] wd,
                      input logic [15:0] erd, input logic eerr);
        client.xfer(s, u, w, r, wd, ok, err, rd);
        `CHK("rsp_valid", 1'b1, ok)
        `CHK("rsp_error", eerr, err)
        `CHK("rsp_rdata", erd, rd)
        `CHK("rsp_tag", {s, u}, {rsp_session_o, rsp_udp_o})
    endtask

    task automatic stop_test();
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Hang guard
    initial
    begin
        repeat (100000) @(posedge clk_i);
        miscompares++;
        stop_test();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        clk_i = 1'b0;
        rst_i = 1'b1;
        fl = 12'h000;
        {prog_bits_i, prog_enable_i} = 4'h0;
        {speed_actual_i, speed_reference_word_i} = 32'h0000_0000;
        supervision_limit_i = 16'h7FFF;
        actual_one_i = 16'h1234;
        actual_two_i = 16'hFEDC;
        repeat (2) @(posedge clk_i);
        #1;
        `CHK("sw_reset", dsp_pkg::STATUS_RESET, drive_status_word_o)
        @(posedge clk_i) rst_i <= 1'b0;
        for (int i = 0; i < 12; i++)
        begin
            @(posedge clk_i) fl <= 12'(1 << i);
            sw_chk();
        end
        for (int i = 0; i < 16; i++)
        begin
            @(posedge clk_i) {prog_bits_i, prog_enable_i} <= 4'(i);
            sw_chk();
        end
        for (int i = 0; i < 6; i++)
        begin
            @(posedge clk_i) {speed_actual_i, speed_reference_word_i,
                              supervision_limit_i} <= SPD[i];
            sw_chk();
        end
        $display("test status_bits done");
        rw(0, 0, 0, 400004, 16'h0000, exp_sw(), 1'b0);
        rw(1, 1, 1, 400001, 16'hA5C3, 16'hA5C3, 1'b0);
        `CHK("control", 16'hA5C3, control_word_o)
        rw(0, 1, 1, 400002, 16'h4E20, 16'h4E20, 1'b0);
        `CHK("ref_one", 16'h4E20, speed_reference_one_o)
        rw(1, 0, 1, 40003, 16'hB1E0, 16'hB1E0, 1'b0);
        `CHK("ref_two", 16'hB1E0, speed_reference_two_o)
        rw(0, 0, 0, 400005, 16'h0000, 16'h1234, 1'b0);
        rw(1, 1, 0, 400006, 16'h0000, 16'hFEDC, 1'b0);
        rw(0, 0, 1, 400004, 16'hFFFF, 16'h0000, 1'b1);
        rw(1, 0, 0, 465536, 16'h0000, 16'h0000, 1'b1);
        rw(0, 0, 0, 400002, 16'h0000, 16'h4E20, 1'b0);
        $display("test registers done");
        @(posedge clk_i) rst_i <= 1'b1;
        @(posedge clk_i);
        #1;
        `CHK("ctl_reset", dsp_pkg::DATA_RESET, control_word_o)
        @(posedge clk_i) rst_i <= 1'b0;
        sw_chk();
        $display("test second_reset done");
        stop_test();
    end
endmodule
